//--- design/ppm_params.svh
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// port geometry
`define PPM_PINS          8

// register byte offsets
`define PPM_DIR_OFS       8'h00
`define PPM_OUTVAL_OFS    8'h04
`define PPM_TOGGLE_OFS    8'h08
`define PPM_PINREAD_OFS   8'h0c
`define PPM_CTRL_OFS      8'h10

// control register fields
`define PPM_CTRL_PUD_BIT  0

// reset values
`define PPM_DIR_RST       8'h00
`define PPM_OUTVAL_RST    8'h00
`define PPM_PUD_RST       1'b0

// ahb encodings
`define PPM_HTRANS_NONSEQ 2'h2
`define PPM_HRESP_OKAY    1'b0

`endif

//--- design/ppm_pkg.sv
package ppm_pkg;

    // override bundle driven by one peripheral for one pin
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic pin_level_override_enable;
        logic pin_level_override_value;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } ppm_override_t;

    // processor sleep state, one-hot
    typedef enum logic [3:0] {
        PPM_ACTIVE     = 4'h1,
        PPM_IDLE       = 4'h2,
        PPM_POWER_DOWN = 4'h4,
        PPM_STANDBY    = 4'h8
    } ppm_sleep_t;

    // latched ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ppm_aphase_t;

endpackage : ppm_pkg

//--- design/ppm_port_mux.sv
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ppm_params.svh"
// Function
// R1: pull-up override enable set: pull-up follows override value only.
// R2: no pull-up override: pull-up on when direction,value,disable are 0,1,0.
// R3: direction override enable set: driver follows direction override value.
// R4: no direction override: driver enabled exactly when direction bit set.
// R5: driver on and level override set: pad driven with override level.
// R6: driver on and no level override: pad driven with output value bit.
// R7: input enable override set: input enable follows override value always.
// R8: no input override: input enable follows processor sleep state.
// R9: peripherals get raw post-Schmitt input, ahead of the synchronizer.
// R10: peripherals synchronize that raw input unless used as a clock.
// R11: analog line to peripherals is wired straight to the pad.
// R12: each peripheral generates override enables and values for its pins.
// R13: strobes shared per port, clock/clamp/disable shared, overrides per pin.
// R14: all pull-ups off while reset is active.
// R15: software should pull up unused pins to avoid floating inputs.
// R16: no overrides: direction set gives output at value bit, else input.
// R17: clamp forces digital input low in power-down and standby.
// R18: override enables of pins without peripheral are tied inactive.
module ppm_port_mux (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // processor state
    input  wire ppm_pkg::ppm_sleep_t     sleep_state,
    // peripheral side, one bundle per pin
    input  wire ppm_pkg::ppm_override_t  ovr [`PPM_PINS],
    output logic [`PPM_PINS-1:0]         schmitt_input_to_peripheral,
    output logic [`PPM_PINS-1:0]         analog_pad_line,
    // pad side
    input  wire logic [`PPM_PINS-1:0]    pad_in,
    output logic [`PPM_PINS-1:0]         pad_out,
    output logic [`PPM_PINS-1:0]         pad_oe_n,
    output logic [`PPM_PINS-1:0]         pad_pullup_en
);

    // register state
    logic [`PPM_PINS-1:0] direction_bit_reg, direction_bit_next;
    logic [`PPM_PINS-1:0] output_value_bit_reg, output_value_bit_next;
    logic                 global_pullup_disable_reg;
    logic                 global_pullup_disable_next;
    ppm_pkg::ppm_aphase_t aph_reg, aph_next;
    logic [31:0]          hrdata_next;

    // pad state
    logic [`PPM_PINS-1:0] sync1_reg, sync2_reg;
    logic [`PPM_PINS-1:0] pad_out_next, pad_oe_n_next, pad_pullup_next;
    logic [`PPM_PINS-1:0] in_en, drv_en;
    logic                 clamp;
    logic [`PPM_PINS-1:0] pin_read;

    // sleep clamp is common to every pin of every port
    assign clamp = (sleep_state == ppm_pkg::PPM_POWER_DOWN) ||
                   (sleep_state == ppm_pkg::PPM_STANDBY); // R17 R13

    // per-pin override muxing, combinational ahead of the pad flops
    always_comb begin
        for (int i = 0; i < `PPM_PINS; i++) begin
            if (ovr[i].direction_override_enable) begin
                drv_en[i] = ovr[i].direction_override_value; // R3
            end else begin
                drv_en[i] = direction_bit_reg[i]; // R4 R16 R18
            end
            if (ovr[i].pin_level_override_enable) begin
                pad_out_next[i] = ovr[i].pin_level_override_value; // R5
            end else begin
                pad_out_next[i] = output_value_bit_reg[i]; // R6 R16
            end
            pad_oe_n_next[i] = ~drv_en[i];
            if (ovr[i].pullup_override_enable) begin
                pad_pullup_next[i] = ovr[i].pullup_override_value; // R1
            end else begin
                pad_pullup_next[i] = ~direction_bit_reg[i] &
                                     output_value_bit_reg[i] &
                                     ~global_pullup_disable_reg; // R2
            end
            if (ovr[i].input_enable_override_enable) begin
                in_en[i] = ovr[i].input_enable_override_value; // R7
            end else begin
                in_en[i] = ~clamp; // R8
            end
        end
    end

    // raw input after the schmitt stage; peripherals synchronize it
    assign schmitt_input_to_peripheral = pad_in & in_en; // R9
    // analog view of the pad, no logic in the path
    assign analog_pad_line = pad_in; // R11

    // synchronized pin value, disabled inputs read as zero
    assign pin_read = sync2_reg;

    // pad flops; reset keeps pull-ups off and drivers tri-stated
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out       <= '0;
            pad_oe_n      <= '1;
            pad_pullup_en <= '0; // R14
            sync1_reg     <= '0;
            sync2_reg     <= '0;
        end else begin
            pad_out       <= pad_out_next;
            pad_oe_n      <= pad_oe_n_next;
            pad_pullup_en <= pad_pullup_next;
            sync1_reg     <= pad_in & in_en;
            sync2_reg     <= sync1_reg;
        end
    end

    // bus decode and register next values
    always_comb begin
        direction_bit_next         = direction_bit_reg;
        output_value_bit_next      = output_value_bit_reg;
        global_pullup_disable_next = global_pullup_disable_reg;
        aph_next.valid = hsel && hready && (htrans == `PPM_HTRANS_NONSEQ);
        aph_next.write = hwrite;
        aph_next.addr  = haddr[7:0];
        // data phase write, strobes shared by all pins of the port
        if (aph_reg.valid && aph_reg.write) begin // R13
            case (aph_reg.addr)
                `PPM_DIR_OFS: begin
                    direction_bit_next = hwdata[`PPM_PINS-1:0];
                end
                `PPM_OUTVAL_OFS: begin
                    output_value_bit_next = hwdata[`PPM_PINS-1:0];
                end
                `PPM_TOGGLE_OFS: begin
                    // write-one toggles the output value bit
                    output_value_bit_next = output_value_bit_reg ^
                                            hwdata[`PPM_PINS-1:0];
                end
                `PPM_CTRL_OFS: begin
                    global_pullup_disable_next = hwdata[`PPM_CTRL_PUD_BIT];
                end
                default: begin
                end
            endcase
        end
        // read data prepared in the address phase so hrdata is a flop
        hrdata_next = 32'h0000_0000;
        if (aph_next.valid && !hwrite) begin
            case (haddr[7:0])
                `PPM_DIR_OFS:     hrdata_next[`PPM_PINS-1:0] =
                                      direction_bit_reg;
                `PPM_OUTVAL_OFS:  hrdata_next[`PPM_PINS-1:0] =
                                      output_value_bit_reg;
                `PPM_PINREAD_OFS: hrdata_next[`PPM_PINS-1:0] = pin_read;
                `PPM_CTRL_OFS:    hrdata_next[`PPM_CTRL_PUD_BIT] =
                                      global_pullup_disable_reg;
                default:          hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // bus and register flops; slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            direction_bit_reg         <= `PPM_DIR_RST;
            output_value_bit_reg      <= `PPM_OUTVAL_RST;
            global_pullup_disable_reg <= `PPM_PUD_RST;
            aph_reg                   <= '0;
            hrdata                    <= 32'h0000_0000;
            hreadyout                 <= 1'b1;
            hresp                     <= `PPM_HRESP_OKAY;
        end else begin
            direction_bit_reg         <= direction_bit_next;
            output_value_bit_reg      <= output_value_bit_next;
            global_pullup_disable_reg <= global_pullup_disable_next;
            aph_reg                   <= aph_next;
            hrdata                    <= hrdata_next;
            hreadyout                 <= 1'b1;
            hresp                     <= `PPM_HRESP_OKAY;
        end
    end

endmodule : ppm_port_mux

//--- tb/ppm_periph_model.sv
`timescale 1ns/1ps
// peripheral stand-in owning pin 0; overrides come from its own flops
module ppm_periph_model (
    input  wire logic             hclk,
    input  wire logic [7:0]       cmd,
    input  wire logic             din,
    output ppm_pkg::ppm_override_t ovr [8],
    output logic                  din_sync
);
    logic meta;
    initial ovr = '{default: '0};
    always @(posedge hclk) begin
        ovr[0] <= cmd;
        for (int i = 1; i < 8; i++) ovr[i] <= '0;
        meta <= din;
        din_sync <= meta;
    end
endmodule : ppm_periph_model

//--- tb/ppm_port_mux_checker.sv
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_port_mux_checker (
    // clock, reset and bus
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    // peripheral and pad side
    input wire ppm_pkg::ppm_sleep_t sleep_state,
    input wire ppm_pkg::ppm_override_t ovr [`PPM_PINS],
    input wire logic [7:0] schmitt_input_to_peripheral, analog_pad_line,
    input wire logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup_en
);
    logic                   live;
    logic                   clamp;
    ppm_pkg::ppm_override_t o;
    // pin 0 carries the peripheral; others stay quiet
    assign o = ovr[0];
    assign clamp = sleep_state inside {ppm_pkg::PPM_POWER_DOWN,
                                       ppm_pkg::PPM_STANDBY};
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // $past is trusted only one edge after release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) live <= 1'b0;
        else live <= 1'b1;
    end
    a_pullup_override: assert property (live && o.pullup_override_enable |=>
        pad_pullup_en[0] == $past(o.pullup_override_value)) else $error("pu");
    a_dir_override: assert property (live && o.direction_override_enable |=>
        pad_oe_n[0] == !$past(o.direction_override_value)) else $error("dir");
    a_level_override: assert property (live && o.direction_override_enable
        && o.direction_override_value && o.pin_level_override_enable |=>
        pad_out[0] == $past(o.pin_level_override_value)) else $error("lvl");
    a_input_override: assert property (o.input_enable_override_enable |->
        schmitt_input_to_peripheral[0] ==
        (pad_in[0] & o.input_enable_override_value)) else $error("ie");
    a_sleep_clamp: assert property (!o.input_enable_override_enable &&
        clamp |-> !schmitt_input_to_peripheral[0]) else $error("clamp");
    a_awake_input: assert property (!o.input_enable_override_enable &&
        !clamp |-> schmitt_input_to_peripheral[0] == pad_in[0])
        else $error("awake");
    a_analog_line: assert property (analog_pad_line == pad_in)
        else $error("analog");
    a_reset_pullup: assert property (disable iff (1'b0)
        !hresetn |-> pad_pullup_en == 8'h00) else $error("reset pu");
    c_pu: cover property (o.pullup_override_enable);
    c_sleep: cover property (clamp ##1 !clamp);
    c_lvl: cover property (o.pin_level_override_enable && !pad_oe_n[0]);
endmodule : ppm_port_mux_checker
bind ppm_port_mux ppm_port_mux_checker u_chk (.*);

//--- tb/test_port_pin_override_mux.sv
`timescale 1ns/1ps
`include "ppm_params.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module test_port_pin_override_mux;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] ext = 8'h00, cmd = 8'h00, sip, apl, pad_in, pad_out, oe_n, pu;
    ppm_pkg::ppm_sleep_t sleep_state = ppm_pkg::PPM_ACTIVE;
    ppm_pkg::ppm_override_t ovr [8];
    int n_fail = 0, n_compared = 0;
    assign hready = hreadyout;
    // pad wire: our driver wins, otherwise the outside source
    assign pad_in = (~oe_n & pad_out) | (oe_n & ext);
    ppm_port_mux u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sleep_state(sleep_state),
        .ovr(ovr), .schmitt_input_to_peripheral(sip), .analog_pad_line(apl),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n),
        .pad_pullup_en(pu));
    ppm_periph_model u_periph (.hclk(hclk), .cmd(cmd), .din(sip[0]),
        .ovr(ovr), .din_sync());
    initial forever #2.5 hclk = ~hclk;
    // one word transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `PPM_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        `CHK("hresp", `PPM_HRESP_OKAY, hresp)
    endtask : bus
    task automatic t_regs;
        bus(1, `PPM_DIR_OFS, 32'h0f, rd);
        bus(1, `PPM_OUTVAL_OFS, 32'h33, rd);
        bus(1, `PPM_TOGGLE_OFS, 32'h11, rd);
        bus(0, `PPM_OUTVAL_OFS, 0, rd);
        `CHK("outval", 32'h22, rd)
        bus(0, 8'h20, 0, rd);
        `CHK("unmapped", 32'h0, rd)
        ext <= 8'hc0;
        repeat (4) @(posedge hclk);
        `CHK("oe_n", 8'hf0, oe_n)
        `CHK("pad_out", 8'h02, pad_out & 8'h0f)
        `CHK("pullup", 8'h20, pu)
        bus(0, `PPM_PINREAD_OFS, 0, rd);
        `CHK("pinread", 32'hc2, rd)
        bus(1, `PPM_CTRL_OFS, 32'h1, rd);
        repeat (3) @(posedge hclk);
        `CHK("pud", 8'h00, pu)
        bus(1, `PPM_CTRL_OFS, 32'h0, rd);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        `CHK("rst_pu", 8'h00, pu)
        hresetn <= 1'b1;
    endtask : t_regs
    task automatic t_sleep;
        ext <= 8'hff;
        for (int i = 0; i < 4; i++) begin
            sleep_state <= ppm_pkg::ppm_sleep_t'(4'h1 << i);
            repeat (2) @(posedge hclk);
            `CHK("input", (i > 1) ? 8'h00 : 8'hff, sip)
        end
        cmd <= 8'h03;
        repeat (3) @(posedge hclk);
        `CHK("ie_ovr", 8'h01, sip)
        `CHK("analog", pad_in, apl)
        sleep_state <= ppm_pkg::PPM_ACTIVE;
    endtask : t_sleep
    // every override pattern against every direction/value pair
    task automatic t_override;
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            bus(1, `PPM_DIR_OFS, {31'h0, k[1]}, rd);
            bus(1, `PPM_OUTVAL_OFS, {31'h0, k[0]}, rd);
            for (int j = 0; j < 256; j++) begin
                c = j[7:0];
                cmd <= c;
                repeat (3) @(posedge hclk);
                #1;
                `CHK("pu", c[7] ? c[6] : !k[1] & k[0], pu[0])
                `CHK("oe", !(c[5] ? c[4] : k[1]), oe_n[0])
                if (oe_n[0] === 1'b0)
                    `CHK("out", c[3] ? c[2] : k[0], pad_out[0])
                `CHK("di", pad_in[0] & (c[1] ? c[0] : 1'b1), sip[0])
            end
        end
    endtask : t_override
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_sleep;
        t_override;
        conclude;
    end
    // run needs about 3200 cycles; give it ample margin
    initial begin
        #60000;
        n_fail++;
        conclude;
    end
endmodule : test_port_pin_override_mux
